// ===== core/fpa_pkg.sv
// Package: register map, fields and timing of the fan ramp block
//
// Functional notes
// - Enabled channel ramps gradually toward new duty
// - Rate code 0-7 steps 1,2,3,4,8,12,24,48
// - 33% to 100% takes 35 s at code 0
// - Rate fields: ch1 [2:0], ch3 [2:0], ch2 [6:4]
// - Ramping only while channel enable bit set
// - Sync bit high: speed inputs 2-4 follow output 3
// - Sync bit low: only speed inputs 3,4 follow
// - Below floor: off, or minimum duty if hold
// - Lock makes both acoustic registers read-only
// - Minimum duty registers at 0x64-0x66, reset 0x80
// - Minimum duty read-only in automatic mode
// - Minimum duty byte maps linearly 0 to 100%
// - Slow bit makes ramp four times longer
// - Above floor, run at least minimum duty
`default_nettype none
package fpa_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned RAMP_FULL_MS = 35000;
    localparam int unsigned RAMP_SPAN = 171;
    localparam int unsigned SLOT_CYCLES =
        (RAMP_FULL_MS * (CLK_HZ / 1000)) / RAMP_SPAN;
    localparam int unsigned SLOW_SLOTS = 4;
    localparam int unsigned SLOT_W = 23;
    // ****************************************
    // Register indices, byte address is four times
    // ****************************************
    localparam logic [7:0] IDX_RAMP1 = 8'h62;
    localparam logic [7:0] IDX_RAMP2 = 8'h63;
    localparam logic [7:0] IDX_MDUTY1 = 8'h64;
    localparam logic [7:0] IDX_MDUTY2 = 8'h65;
    localparam logic [7:0] IDX_MDUTY3 = 8'h66;
    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int unsigned RATE1_LSB = 0;
    localparam int unsigned RAMPEN1_BIT = 3;
    localparam int unsigned SYNC_BIT = 4;
    localparam int unsigned HOLD1_BIT = 5;
    localparam int unsigned RATE3_LSB = 0;
    localparam int unsigned RAMPEN3_BIT = 3;
    localparam int unsigned RATE2_LSB = 4;
    localparam int unsigned RAMPEN2_BIT = 7;
    localparam logic [7:0] RAMP_CTL_RST = 8'h00;
    localparam logic [7:0] MIN_DUTY_RST = 8'h80;

    typedef enum logic {BUS_IDLE, BUS_RDWAIT} fpa_bus_t;

    // Duty increase per slot for a rate code
    function automatic logic [7:0] rateStep(input logic [2:0] code);
        case (code)
            3'h0: rateStep = 8'h01;
            3'h1: rateStep = 8'h02;
            3'h2: rateStep = 8'h03;
            3'h3: rateStep = 8'h04;
            3'h4: rateStep = 8'h08;
            3'h5: rateStep = 8'h0C;
            3'h6: rateStep = 8'h18;
            default: rateStep = 8'h30;
        endcase
    endfunction
endpackage
`default_nettype wire

// ===== core/fpa_ramp_if.sv
// Interface: ramp control and duty of one channel
`timescale 1ns/1ns
`default_nettype none
interface fpa_ramp_if;
    logic clkEn;
    logic slotTick;
    logic en;
    logic slow;
    logic [2:0] rate;
    logic [7:0] target;
    logic [7:0] duty;
    modport ctl (output clkEn, slotTick, en, slow, rate, target, input duty);
    modport ramp (input clkEn, slotTick, en, slow, rate, target, output duty);
endinterface
`default_nettype wire

// ===== core/fpa_ramp_ch.sv
// Module: duty ramp of one fan channel
`timescale 1ns/1ns
`default_nettype none
module fpa_ramp_ch (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Control and duty
    fpa_ramp_if.ramp rif
);
    import fpa_pkg::*;
    logic [7:0] duty_reg;
    logic [1:0] slowCnt_reg;
    logic [7:0] step;
    logic advance;

    assign step = rateStep(rif.rate);
    assign advance = rif.slotTick &&
        (!rif.slow || slowCnt_reg == 2'(SLOW_SLOTS - 1));
    assign rif.duty = duty_reg;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            slowCnt_reg <= 2'h0;
        end else if (rif.clkEn && rif.slotTick) begin
            slowCnt_reg <= rif.slow ? slowCnt_reg + 2'h1 : 2'h0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            duty_reg <= 8'h00;
        end else if (rif.clkEn) begin
            if (!rif.en) begin
                duty_reg <= rif.target;
            end else if (advance) begin
                if (rif.target > duty_reg) begin
                    duty_reg <= (rif.target - duty_reg > step) ?
                        duty_reg + step : rif.target;
                end else if (rif.target < duty_reg) begin
                    duty_reg <= (duty_reg - rif.target > step) ?
                        duty_reg - step : rif.target;
                end
            end
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    AST_OFF_FOLLOW: assert property (rif.clkEn && !rif.en |=> duty_reg == $past(rif.target))
        else $error("disabled channel did not follow target");
    AST_UP_EXACT: assert property (rif.clkEn && rif.en && advance
        && {1'b0, rif.target} > {1'b0, duty_reg} + {1'b0, step}
        |=> duty_reg == $past(duty_reg) + $past(step))
        else $error("upward step not equal to rate");
    AST_NO_OVERSHOOT: assert property (rif.clkEn && rif.en && duty_reg < rif.target
        |=> duty_reg <= $past(rif.target))
        else $error("ramp overshot target");
    AST_HOLD: assert property (rif.clkEn && rif.en && !advance |=> $stable(duty_reg))
        else $error("duty moved outside a slot");
    AST_SLOW4: assert property (rif.clkEn && rif.en && rif.slow && advance
        |-> slowCnt_reg == 2'h3)
        else $error("slow ramp advanced early");
    COV_RAMP_DONE: cover property (rif.en && advance ##1 duty_reg == rif.target);
endmodule // fpa_ramp_ch
`default_nettype wire

// ===== core/fpa_tach_sync.sv
// Module: gates speed inputs to the third drive output
`timescale 1ns/1ns
`default_nettype none
module fpa_tach_sync (
    // Clock, reset and enable
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clkEn,
    // Control
    input wire logic syncAll,
    input wire logic drive3High,
    // Speed inputs 2, 3, 4 and gated copies
    input wire logic [2:0] speedIn,
    output logic [2:0] measure
);
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            measure <= 3'h0;
        end else if (clkEn) begin
            measure[0] <= speedIn[0] && (!syncAll || drive3High);
            measure[2:1] <= speedIn[2:1] & {2{drive3High}};
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    AST_SYNC_ALL: assert property (clkEn && syncAll && !drive3High |=> measure == 3'h0)
        else $error("speed input measured outside drive window");
    AST_SYNC_TWO: assert property (clkEn && !syncAll |=> measure[0] == $past(speedIn[0]))
        else $error("speed input 2 gated while sync is off");
    COV_SYNC: cover property (syncAll && drive3High && speedIn[0] ##1 measure[0]);
endmodule // fpa_tach_sync
`default_nettype wire

// ===== core/fpa_ramp_top.sv
// Module: acoustic ramp and minimum duty control with AHB-Lite registers
`timescale 1ns/1ns
`default_nettype none
module fpa_ramp_top #(
    parameter int unsigned SLOT_CYCLES = fpa_pkg::SLOT_CYCLES
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clkEn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Control state from the rest of the device
    input wire logic autoMode,
    input wire logic cfgLock,
    input wire logic [2:0] slowRamp,
    input wire logic [2:0] belowFloor,
    input wire logic [23:0] calcDuty,
    // Speed inputs and drive level
    input wire logic fanSpeedInput2,
    input wire logic fanSpeedInput3,
    input wire logic fanSpeedInput4,
    input wire logic fanDrive3High,
    // Outputs
    output logic [7:0] fanDriveDuty1,
    output logic [7:0] fanDriveDuty2,
    output logic [7:0] fanDriveDuty3,
    output logic [2:0] speedMeasure,
    output logic lockState
);
    import fpa_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] rampCtl1_reg;
    logic [7:0] rampCtl2_reg;
    logic [7:0] minDuty_reg [3];
    logic lockSeen_reg;
    logic [SLOT_W-1:0] slotCnt_reg;
    logic slotTick_reg;
    fpa_bus_t busState_reg;
    logic dphWr_reg;
    logic dphHit_reg;
    logic [7:0] dphIdx_reg;
    logic [7:0] target_reg [3];

    // ****************************************
    // Bus decode
    // ****************************************
    logic accept;
    logic hitNext;
    logic wrEn;
    logic locked;
    logic [7:0] wrByte;
    logic [7:0] readByte;

    assign accept = hsel && htrans[1] && hready;
    assign hitNext = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
    assign wrEn = clkEn && busState_reg == BUS_IDLE && dphWr_reg && dphHit_reg;
    assign wrByte = hwdata[7:0];
    assign locked = lockSeen_reg || cfgLock;

    always_comb begin
        readByte = 8'h00;
        if (dphHit_reg) begin
            case (dphIdx_reg)
                IDX_RAMP1: readByte = rampCtl1_reg;
                IDX_RAMP2: readByte = rampCtl2_reg;
                IDX_MDUTY1: readByte = minDuty_reg[0];
                IDX_MDUTY2: readByte = minDuty_reg[1];
                IDX_MDUTY3: readByte = minDuty_reg[2];
                default: readByte = 8'h00;
            endcase
        end
    end

    // Writes take no wait; reads take one so read data sees the last write
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busState_reg <= BUS_IDLE;
            hreadyout <= 1'b1;
            hrdata <= 32'h0;
            hresp <= 1'b0;
            dphWr_reg <= 1'b0;
            dphHit_reg <= 1'b0;
            dphIdx_reg <= 8'h00;
        end else if (clkEn) begin
            hresp <= 1'b0;
            case (busState_reg)
                BUS_IDLE: begin
                    dphWr_reg <= accept && hwrite;
                    if (accept) begin
                        dphIdx_reg <= haddr[9:2];
                        dphHit_reg <= hitNext;
                    end
                    if (accept && !hwrite) begin
                        busState_reg <= BUS_RDWAIT;
                        hreadyout <= 1'b0;
                    end else begin
                        hreadyout <= 1'b1;
                    end
                end
                BUS_RDWAIT: begin
                    hrdata <= {24'h0, readByte};
                    hreadyout <= 1'b1;
                    dphWr_reg <= 1'b0;
                    busState_reg <= BUS_IDLE;
                end
                default: begin
                    busState_reg <= BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // Lock and acoustic registers
    // ****************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lockSeen_reg <= 1'b0;
        end else if (clkEn && cfgLock) begin
            lockSeen_reg <= 1'b1;
        end
    end

    assign lockState = lockSeen_reg;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rampCtl1_reg <= RAMP_CTL_RST;
            rampCtl2_reg <= RAMP_CTL_RST;
        end else if (wrEn && !locked) begin
            if (dphIdx_reg == IDX_RAMP1) begin
                rampCtl1_reg <= wrByte;
            end
            if (dphIdx_reg == IDX_RAMP2) begin
                rampCtl2_reg <= wrByte;
            end
        end
    end

    // ****************************************
    // Minimum duty registers
    // ****************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 3; i++) begin
                minDuty_reg[i] <= MIN_DUTY_RST;
            end
        end else if (wrEn && !autoMode) begin
            for (int i = 0; i < 3; i++) begin
                if (dphIdx_reg == IDX_MDUTY1 + 8'(i)) begin
                    minDuty_reg[i] <= wrByte;
                end
            end
        end
    end

    // ****************************************
    // Monitoring time slot
    // ****************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            slotCnt_reg <= '0;
            slotTick_reg <= 1'b0;
        end else if (clkEn) begin
            if (slotCnt_reg == SLOT_W'(SLOT_CYCLES - 1)) begin
                slotCnt_reg <= '0;
                slotTick_reg <= 1'b1;
            end else begin
                slotCnt_reg <= slotCnt_reg + SLOT_W'(1);
                slotTick_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Per-channel fields and target duty
    // ****************************************
    logic [2:0] rateSel [3];
    logic [2:0] rampEn;
    logic [2:0] holdMin;
    logic [7:0] calc [3];

    always_comb begin
        rateSel[0] = rampCtl1_reg[RATE1_LSB +: 3];
        rateSel[1] = rampCtl2_reg[RATE2_LSB +: 3];
        rateSel[2] = rampCtl2_reg[RATE3_LSB +: 3];
        rampEn[0] = rampCtl1_reg[RAMPEN1_BIT];
        rampEn[1] = rampCtl2_reg[RAMPEN2_BIT];
        rampEn[2] = rampCtl2_reg[RAMPEN3_BIT];
        holdMin = rampCtl1_reg[HOLD1_BIT +: 3];
        calc[0] = calcDuty[7:0];
        calc[1] = calcDuty[15:8];
        calc[2] = calcDuty[23:16];
    end

    // Target registered so the ramp sees a clean value
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 3; i++) begin
                target_reg[i] <= 8'h00;
            end
        end else if (clkEn) begin
            for (int i = 0; i < 3; i++) begin
                if (autoMode && belowFloor[i]) begin
                    target_reg[i] <= holdMin[i] ? minDuty_reg[i] : 8'h00;
                end else if (autoMode && calc[i] < minDuty_reg[i]) begin
                    target_reg[i] <= minDuty_reg[i];
                end else begin
                    target_reg[i] <= calc[i];
                end
            end
        end
    end

    // ****************************************
    // Ramp channels
    // ****************************************
    fpa_ramp_if rampBus[3] ();
    logic [7:0] dutyCh [3];

    for (genvar g = 0; g < 3; g++) begin : gCh
        assign rampBus[g].clkEn = clkEn;
        assign rampBus[g].slotTick = slotTick_reg;
        assign rampBus[g].en = rampEn[g];
        assign rampBus[g].slow = slowRamp[g];
        assign rampBus[g].rate = rateSel[g];
        assign rampBus[g].target = target_reg[g];
        assign dutyCh[g] = rampBus[g].duty;
        fpa_ramp_ch uRamp (
            .mclk(mclk),
            .arst_n(arst_n),
            .rif(rampBus[g])
        );
    end

    assign fanDriveDuty1 = dutyCh[0];
    assign fanDriveDuty2 = dutyCh[1];
    assign fanDriveDuty3 = dutyCh[2];

    // ****************************************
    // Speed input synchronisation
    // ****************************************
    fpa_tach_sync uTach (
        .mclk(mclk),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .syncAll(rampCtl1_reg[SYNC_BIT]),
        .drive3High(fanDrive3High),
        .speedIn({fanSpeedInput4, fanSpeedInput3, fanSpeedInput2}),
        .measure(speedMeasure)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    AST_LOCK: assert property (wrEn && locked |=> $stable(rampCtl1_reg) && $stable(rampCtl2_reg))
        else $error("acoustic register changed while locked");
    AST_MIN_AUTO: assert property (wrEn && autoMode |=> $stable(minDuty_reg[0])
        && $stable(minDuty_reg[1]) && $stable(minDuty_reg[2]))
        else $error("minimum duty written in automatic mode");
    AST_BELOW_OFF: assert property (clkEn && autoMode && belowFloor[0] && !holdMin[0]
        |=> target_reg[0] == 8'h00)
        else $error("channel 1 not off below floor");
    AST_BELOW_HOLD: assert property (clkEn && autoMode && belowFloor[1] && holdMin[1]
        |=> target_reg[1] == $past(minDuty_reg[1]))
        else $error("channel 2 not at minimum below floor");
    AST_RD_WAIT: assert property (clkEn && busState_reg == BUS_IDLE && accept && !hwrite
        |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    COV_LOCKED_WRITE: cover property (wrEn && locked);
    COV_SLOT: cover property (slotTick_reg && rampEn[0]);
endmodule // fpa_ramp_top
`default_nettype wire

// ===== tb/fpa_fan_model.sv
// Partner model: fan whose speed pulse rate follows its drive duty
`timescale 1ns/1ns
`default_nettype none
module fpa_fan_model #(
    parameter int unsigned PHASE = 0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Drive duty and speed pulse
    input wire logic [7:0] duty,
    output logic speedPulse
);
    logic [8:0] phaseReg;

    // A stopped fan gives no pulses; faster drive, denser pulses
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            phaseReg <= 9'(PHASE);
            speedPulse <= 1'b0;
        end else begin
            phaseReg <= {1'b0, phaseReg[7:0]} + {1'b0, duty};
            speedPulse <= phaseReg[8];
        end
    end
endmodule // fpa_fan_model
`default_nettype wire

// ===== tb/test_fan_pwm_acoustic_ramp_control.sv
// Testbench: ramp, register and speed gating checks against a bench model
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_fan_pwm_acoustic_ramp_control;
    import fpa_pkg::*;
    localparam int unsigned SLOT = 8;
    logic mclk = 1'b0;
    logic arst_n, clkEn, hsel, hwrite, autoMode, cfgLock, fanDrive3High, locked;
    logic hreadyout, hresp, lockState;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, slowRamp, belowFloor, speedMeasure, expMeas, code;
    logic [23:0] calcDuty;
    wire [7:0] duty [3];
    wire [2:0] speedIn;
    logic [7:0] regModel [5];
    logic [7:0] prevD [3];
    logic [7:0] lastT [3];
    logic [7:0] t, e;
    logic rampPrev [3];
    int stab [3];
    int gap [3];
    int stepTab [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
    int fails = 0;
    int checks = 0;
    int seed = 70584;
    int i, k, s, df;

    fpa_ramp_top #(.SLOT_CYCLES(SLOT)) i_fpa_ramp_top (.mclk(mclk), .arst_n(arst_n),
        .clkEn(clkEn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .autoMode(autoMode), .cfgLock(cfgLock),
        .slowRamp(slowRamp), .belowFloor(belowFloor), .calcDuty(calcDuty),
        .fanSpeedInput2(speedIn[0]), .fanSpeedInput3(speedIn[1]),
        .fanSpeedInput4(speedIn[2]), .fanDrive3High(fanDrive3High),
        .fanDriveDuty1(duty[0]), .fanDriveDuty2(duty[1]), .fanDriveDuty3(duty[2]),
        .speedMeasure(speedMeasure), .lockState(lockState));
    fpa_fan_model #(.PHASE(0)) i_fpa_fan_model_a (.mclk(mclk), .arst_n(arst_n),
        .duty(duty[1]), .speedPulse(speedIn[0]));
    fpa_fan_model #(.PHASE(100)) i_fpa_fan_model_b (.mclk(mclk), .arst_n(arst_n),
        .duty(duty[2]), .speedPulse(speedIn[1]));
    fpa_fan_model #(.PHASE(200)) i_fpa_fan_model_c (.mclk(mclk), .arst_n(arst_n),
        .duty(duty[2]), .speedPulse(speedIn[2]));

    always #20 mclk = ~mclk;
    always @(posedge mclk) fanDrive3High <= 1'($random(seed));

    // ****************************************
    // Bench model
    // ****************************************
    function automatic logic enOf(input int c);
        enOf = (c == 0) ? regModel[0][3] : (c == 1) ? regModel[1][7] : regModel[1][3];
    endfunction
    function automatic int stepOf(input int c);
        stepOf = stepTab[(c == 0) ? regModel[0][2:0] :
                         (c == 1) ? regModel[1][6:4] : regModel[1][2:0]];
    endfunction
    function automatic logic [7:0] tgtOf(input int c);
        logic [7:0] mn;
        logic [7:0] cd;
        mn = regModel[2 + c];
        cd = calcDuty[8 * c +: 8];
        if (!autoMode)
            tgtOf = cd;
        else if (belowFloor[c])
            tgtOf = regModel[0][5 + c] ? mn : 8'h00;
        else
            tgtOf = (cd > mn) ? cd : mn;
    endfunction

    // Duty changes of enabled channels are judged against the step rules and slot spacing
    always @(posedge mclk) begin
        if (!arst_n) begin
            expMeas = 3'h0;
            for (int c = 0; c < 3; c++) begin
                prevD[c] = 8'h00;
                lastT[c] = 8'h00;
                rampPrev[c] = 1'b0;
                stab[c] = 0;
                gap[c] = 0;
            end
        end else begin
            `CHK(speedMeasure, expMeas)
            if (clkEn)
                expMeas = {speedIn[2] & fanDrive3High, speedIn[1] & fanDrive3High,
                       speedIn[0] & (fanDrive3High | ~regModel[0][4])};
            for (int c = 0; c < 3; c++) begin
                t = tgtOf(c);
                stab[c] = (t == lastT[c]) ? stab[c] + 1 : 0;
                lastT[c] = t;
                if (duty[c] !== prevD[c]) begin
                    if (enOf(c) && stab[c] > 3) begin
                        df = (t > prevD[c]) ? t - prevD[c] : prevD[c] - t;
                        s = (df < stepOf(c)) ? df : stepOf(c);
                        e = (t > prevD[c]) ? prevD[c] + 8'(s) : prevD[c] - 8'(s);
                        `CHK(duty[c], e)
                    end
                    if (enOf(c) && rampPrev[c])
                        `CHK(gap[c] + 1 >= SLOT * (slowRamp[c] ? 4 : 1), 1'b1)
                    rampPrev[c] = enOf(c);
                    gap[c] = 0;
                    prevD[c] = duty[c];
                end else begin
                    gap[c]++;
                end
            end
        end
    end

    // ****************************************
    // Bus and wait tasks
    // ****************************************
    task automatic final_report;
        if (fails == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic waitReady;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            final_report();
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        htrans <= 2'h2;
        waitReady();
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        waitReady();
        rd = hrdata;
        `CHK(hresp, 1'b0)
    endtask
    task automatic wrReg(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd);
        k = idx - IDX_RAMP1;
        if (idx >= IDX_RAMP1 && idx <= IDX_MDUTY3 && ((k < 2) ? !locked : !autoMode))
            regModel[k] <= wd;
    endtask
    task automatic rdChk(input logic [7:0] idx);
        bus(1'b0, idx, 8'h00);
        k = idx - IDX_RAMP1;
        e = (idx >= IDX_RAMP1 && idx <= IDX_MDUTY3) ? regModel[k] : 8'h00;
        `CHK(rd, {24'h0, e})
    endtask
    task automatic settle;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while ((duty[0] !== tgtOf(0) || duty[1] !== tgtOf(1) ||
                    duty[2] !== tgtOf(2)) && n < 12000);
        if (n >= 12000) begin
            fails++;
            final_report();
        end
        for (int c = 0; c < 3; c++)
            `CHK(duty[c], tgtOf(c))
    endtask

    // ****************************************
    // Stimulus
    // ****************************************
    initial begin
        arst_n = 1'b0; clkEn = 1'b1; hsel = 1'b1; hsize = 3'h2; htrans = 2'h0;
        hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0; autoMode = 1'b0; cfgLock = 1'b0;
        slowRamp = 3'h0; belowFloor = 3'h0; calcDuty = 24'h0;
        locked = 1'b0;
        regModel = '{RAMP_CTL_RST, RAMP_CTL_RST, MIN_DUTY_RST, MIN_DUTY_RST, MIN_DUTY_RST};
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        for (i = 0; i < 7; i++)
            rdChk(8'h61 + 8'(i));
        calcDuty <= 24'($random(seed));
        settle();
        for (i = 0; i < 8; i++) begin
            code = 3'(i);
            wrReg(IDX_RAMP1, {3'h0, code[0], 1'b1, code});
            wrReg(IDX_RAMP2, {1'b1, code + 3'h1, 1'b1, code + 3'h2});
            rdChk(IDX_RAMP2);
            slowRamp <= (i > 5) ? 3'($random(seed)) : 3'h0;
            calcDuty <= 24'($random(seed));
            settle();
        end
        for (i = 0; i < 3; i++) begin
            wrReg(IDX_MDUTY1 + 8'(i), 8'($random(seed)));
            rdChk(IDX_MDUTY1 + 8'(i));
        end
        autoMode <= 1'b1;
        @(posedge mclk);
        wrReg(IDX_MDUTY2, 8'h3C);
        rdChk(IDX_MDUTY2);
        for (i = 0; i < 6; i++) begin
            wrReg(IDX_RAMP1, {3'($random(seed)), 1'b1, 1'b1, 3'h7});
            belowFloor <= 3'($random(seed));
            calcDuty <= 24'($random(seed));
            settle();
        end
        // Clock enable low freezes the ramps and targets while the calculated duty moves
        rd = {8'h00, duty[2], duty[1], duty[0]};
        clkEn <= 1'b0;
        calcDuty <= ~calcDuty;
        repeat (20) @(posedge mclk);
        `CHK({duty[2], duty[1], duty[0]}, rd[23:0])
        clkEn <= 1'b1;
        settle();
        cfgLock <= 1'b1;
        locked = 1'b1;
        @(posedge mclk);
        cfgLock <= 1'b0;
        wrReg(IDX_RAMP1, 8'hA5);
        wrReg(IDX_RAMP2, 8'h5A);
        rdChk(IDX_RAMP1);
        rdChk(IDX_RAMP2);
        `CHK(lockState, 1'b1)
        autoMode <= 1'b0;
        @(posedge mclk);
        wrReg(IDX_MDUTY3, 8'h40);
        rdChk(IDX_MDUTY3);
        final_report();
    end
endmodule // test_fan_pwm_acoustic_ramp_control
`default_nettype wire
